/* File: core/pmicsp_pkg.sv */
// package of constants and carriers for the pmic serial control port
// Functional notes
// - target only: never drives start, stop, clock
// - works at 100 and 400 kbps
// - start: data falls while clock high
// - stop: data rises while clock high, ends transfer
// - bus busy from start until stop
// - every byte exactly eight bits
// - unlimited bytes per transfer
// - receiver acknowledges in ninth clock slot
// - bytes shifted most significant bit first
// - address 1110010 plus select pin as bit0
// - write: address, sub-address, data, each acknowledged
// - read without sub-address uses last written one; code uses the pointer, stepped per written data byte and acked read byte
// - reset pin holds control logic initial
package pmicsp_pkg;
  localparam logic [5:0] ADDR_HI     = 6'h39; // upper six bits 111001
  localparam int         REG_AW      = 8;
  localparam int         REG_DW      = 8;
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] ACK_SLOT    = 4'h8;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [7:0] SUB_RST     = 8'h00;

  typedef enum logic [5:0] {
    PMICSP_IDLE = 6'b000001,
    PMICSP_ADDR = 6'b000010,
    PMICSP_SUB  = 6'b000100,
    PMICSP_WDAT = 6'b001000,
    PMICSP_RDAT = 6'b010000,
    PMICSP_SKIP = 6'b100000
  } pmicsp_state_t;

  // synchronised bus view, one cycle edge flags
  typedef struct packed {
    logic sclRise;
    logic sclFall;
    logic sclHigh;
    logic sda;
    logic start;
    logic stop;
  } pmicsp_bus_t;

  // register-file write strobe group
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } pmicsp_wr_t;
endpackage

/* File: core/pmicsp_sync.sv */
// two-flop synchroniser and edge finder for scl and sda
`timescale 1ns/1ps
`default_nettype none
module pmicsp_sync (
  input  wire logic                     mclk,
  input  wire logic                     rstSyncB,
  input  wire logic                     sclIn,
  input  wire logic                     sdaIn,
  output pmicsp_pkg::pmicsp_bus_t       bus
);
  typedef struct packed {
    logic [1:0] sclMeta;
    logic [1:0] sdaMeta;
    logic       sclD;
    logic       sdaD;
  } pmicsp_sync_t;

  pmicsp_sync_t s_r;
  pmicsp_sync_t s_nxt;

  // meta flops feed only the second stage; edges look at stage two and its delay
  // 4 ns sampling leaves many samples per phase even at 400 kbps
  always_comb begin
    s_nxt         = s_r;
    s_nxt.sclMeta = {s_r.sclMeta[0], sclIn};
    s_nxt.sdaMeta = {s_r.sdaMeta[0], sdaIn};
    s_nxt.sclD    = s_r.sclMeta[1];
    s_nxt.sdaD    = s_r.sdaMeta[1];
  end

  // idle bus is high on both lines
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_r <= '{sclMeta: 2'h3, sdaMeta: 2'h3, sclD: 1'b1, sdaD: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    bus.sclRise = s_r.sclMeta[1] & ~s_r.sclD;
    bus.sclFall = ~s_r.sclMeta[1] & s_r.sclD;
    bus.sclHigh = s_r.sclMeta[1] & s_r.sclD;
    bus.sda     = s_r.sdaMeta[1];
    bus.start   = bus.sclHigh & s_r.sdaD & ~s_r.sdaMeta[1];
    bus.stop    = bus.sclHigh & ~s_r.sdaD & s_r.sdaMeta[1];
  end
endmodule
`default_nettype wire

/* File: core/pmicsp_top.sv */
// serial control port: i2c target with sub-addressed register file
`timescale 1ns/1ps
`default_nettype none
module pmicsp_top #(
  parameter int NREGS = 256
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic        targetAddressSelectPin,
  output logic             busBusy,
  output logic             regWe,
  output logic [7:0]       regAddr,
  output logic [7:0]       regWdata
);
  initial begin
    if (NREGS < 1 || NREGS > 256) $error("NREGS must be 1..256");
  end

  typedef struct packed {
    pmicsp_pkg::pmicsp_state_t st;
    logic [3:0]                bitCnt;
    logic [7:0]                shift;
    logic [7:0]                subAddr;
    logic                      ackDrv;
    logic                      ackPend;
    logic                      mstNack;
    logic                      busy;
    logic                      sawRise;
    logic [1:0]                selSync;
    pmicsp_pkg::pmicsp_wr_t    wr;
  } pmicsp_top_t;

  logic [1:0]             rstMeta_r;
  logic                   rstSyncB;
  pmicsp_pkg::pmicsp_bus_t bus;
  pmicsp_top_t            s_r;
  pmicsp_top_t            s_nxt;
  logic [7:0]             regMem_r [NREGS];
  logic [7:0]             rdByte;
  logic [7:0]             rdPtr;

  // reset released through two flops; asserts immediately
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 2'h0;
    end else begin
      rstMeta_r <= {rstMeta_r[0], 1'b1};
    end
  end
  assign rstSyncB = rstMeta_r[1];

  pmicsp_sync u_sync (
    .mclk     (mclk),
    .rstSyncB (rstSyncB),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .bus      (bus)
  );

  // out-of-range sub-addresses read back as zero; pointer taken from registers to avoid a comb loop
  assign rdPtr  = (s_r.st == pmicsp_pkg::PMICSP_RDAT) ? s_r.subAddr + 8'h01 : s_r.subAddr;
  assign rdByte = (32'(rdPtr) < NREGS) ? regMem_r[rdPtr] : 8'h00;

  // byte engine; scl rising samples, scl falling moves to next slot
  always_comb begin
    s_nxt          = s_r;
    s_nxt.wr.we    = 1'b0;
    s_nxt.selSync  = {s_r.selSync[0], targetAddressSelectPin};
    if (bus.stop) begin
      s_nxt.st     = pmicsp_pkg::PMICSP_IDLE;
      s_nxt.busy   = 1'b0;
      s_nxt.ackDrv = 1'b0;
    end else if (bus.start) begin
      // repeated start also lands here
      s_nxt.st      = pmicsp_pkg::PMICSP_ADDR;
      s_nxt.busy    = 1'b1;
      s_nxt.bitCnt  = 4'h0;
      s_nxt.ackDrv  = 1'b0;
      s_nxt.ackPend = 1'b0;
      s_nxt.sawRise = 1'b0;  // the scl fall closing the start is not a bit
    end else if (s_r.st != pmicsp_pkg::PMICSP_IDLE && s_r.st != pmicsp_pkg::PMICSP_SKIP) begin
      if (bus.sclRise) begin
        s_nxt.sawRise = 1'b1;
        if (s_r.bitCnt <= pmicsp_pkg::BIT_LAST && s_r.st != pmicsp_pkg::PMICSP_RDAT) begin
          s_nxt.shift = {s_r.shift[6:0], bus.sda};
        end else if (s_r.bitCnt == pmicsp_pkg::ACK_SLOT && s_r.st == pmicsp_pkg::PMICSP_RDAT) begin
          s_nxt.mstNack = bus.sda;
        end
      end else if (bus.sclFall && s_r.sawRise) begin
        if (s_r.bitCnt == pmicsp_pkg::BIT_LAST) begin
          s_nxt.bitCnt = pmicsp_pkg::ACK_SLOT;
          case (s_r.st)
            pmicsp_pkg::PMICSP_ADDR: begin
              if (s_r.shift[7:2] == pmicsp_pkg::ADDR_HI && s_r.shift[1] == s_r.selSync[1]) begin
                s_nxt.ackDrv = 1'b1;
              end else begin
                s_nxt.st = pmicsp_pkg::PMICSP_SKIP;
              end
            end
            pmicsp_pkg::PMICSP_SUB,
            pmicsp_pkg::PMICSP_WDAT: begin
              s_nxt.ackDrv  = 1'b1;
              s_nxt.ackPend = 1'b1;
            end
            default: begin
              s_nxt.ackDrv = 1'b0;  // read: master acknowledges
            end
          endcase
        end else if (s_r.bitCnt == pmicsp_pkg::ACK_SLOT) begin
          // end of ninth slot: release sda, pick next phase
          s_nxt.bitCnt  = 4'h0;
          s_nxt.ackDrv  = 1'b0;
          s_nxt.ackPend = 1'b0;
          case (s_r.st)
            pmicsp_pkg::PMICSP_ADDR: begin
              if (s_r.shift[0]) begin
                s_nxt.st    = pmicsp_pkg::PMICSP_RDAT;
                s_nxt.shift = rdByte;
              end else begin
                s_nxt.st = pmicsp_pkg::PMICSP_SUB;
              end
            end
            pmicsp_pkg::PMICSP_SUB: begin
              s_nxt.subAddr = s_r.shift;
              s_nxt.st      = pmicsp_pkg::PMICSP_WDAT;
            end
            pmicsp_pkg::PMICSP_WDAT: begin
              s_nxt.wr.we   = 1'b1;
              s_nxt.wr.addr = s_r.subAddr;
              s_nxt.wr.data = s_r.shift;
              s_nxt.subAddr = s_r.subAddr + 8'h01;
            end
            pmicsp_pkg::PMICSP_RDAT: begin
              if (s_r.mstNack) begin
                s_nxt.st = pmicsp_pkg::PMICSP_SKIP;
              end else begin
                s_nxt.subAddr = s_r.subAddr + 8'h01;
                s_nxt.shift   = rdByte;
              end
            end
            default: begin
              s_nxt.st = pmicsp_pkg::PMICSP_IDLE;
            end
          endcase
        end else begin
          s_nxt.bitCnt = s_r.bitCnt + 4'h1;
          if (s_r.st == pmicsp_pkg::PMICSP_RDAT) begin
            s_nxt.shift = {s_r.shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  // sub-address pointer keeps its value between transfers
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      s_r <= '{st: pmicsp_pkg::PMICSP_IDLE, bitCnt: 4'h0, shift: 8'h00,
               subAddr: pmicsp_pkg::SUB_RST, ackDrv: 1'b0, ackPend: 1'b0,
               mstNack: 1'b0, busy: 1'b0, sawRise: 1'b0, selSync: 2'h0,
               wr: '{we: 1'b0, addr: 8'h00, data: 8'h00}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // register file behind the port
  always_ff @(posedge mclk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      for (int i = 0; i < NREGS; i++) begin
        regMem_r[i] <= pmicsp_pkg::REG_RST;
      end
    end else if (s_r.wr.we && 32'(s_r.wr.addr) < NREGS) begin
      regMem_r[s_r.wr.addr] <= s_r.wr.data;
    end
  end

  // open-drain: only ever pull low, never touch scl
  always_comb begin
    sdaOut = 1'b0;
    if (s_r.st == pmicsp_pkg::PMICSP_RDAT && s_r.bitCnt <= pmicsp_pkg::BIT_LAST) begin
      sdaOe = ~s_r.shift[7];
    end else begin
      sdaOe = s_r.ackDrv;
    end
  end

  assign busBusy  = s_r.busy;
  assign regWe    = s_r.wr.we;
  assign regAddr  = s_r.wr.addr;
  assign regWdata = s_r.wr.data;
endmodule
`default_nettype wire

/* File: test/pmicsp_monitor.sv */
// assertion checker on the control port pins
`timescale 1ns/1ps
`default_nettype none
module pmicsp_monitor (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       sclIn,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       targetAddressSelectPin,
  input wire logic       busBusy,
  input wire logic       regWe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // raw pin conditions, ahead of the synchroniser
  sequence s_start; sclIn && $past(sclIn) && $fell(sdaIn); endsequence
  sequence s_stop; sclIn && $past(sclIn) && $rose(sdaIn); endsequence
  property p_pull; sdaOe |-> !sdaOut; endproperty
  a_pull: assert property (p_pull) else $error("sda driven high");
  property p_start; s_start |-> ##[1:6] busBusy; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_stop; s_stop |-> ##[1:6] !busBusy; endproperty
  a_stop: assert property (p_stop) else $error("stop missed");
  property p_idle; !busBusy |-> !sdaOe; endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
  property p_ack; $rose(sdaOe) |-> sdaOe [*4]; endproperty
  a_ack: assert property (p_ack) else $error("ack too short");
  property p_pulse; regWe |=> !regWe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_commit; regWe |-> !sdaOe && busBusy && ($past(sdaOe) || $past(sdaOe, 2)); endproperty
  a_commit: assert property (p_commit) else $error("strobe before ack end");
  property p_hold; regWe |=> $stable(regAddr) && $stable(regWdata); endproperty
  a_hold: assert property (p_hold) else $error("strobe data moved");
endmodule
bind pmicsp_top pmicsp_monitor u_mon (.mclk, .rst_b, .sclIn, .sdaIn, .sdaOut, .sdaOe,
  .targetAddressSelectPin, .busBusy, .regWe, .regAddr, .regWdata);
`default_nettype wire

/* File: test/pmicsp_master.sv */
// bus master model driving the control port link
`timescale 1ns/1ps
`default_nettype none
module pmicsp_master (
  output logic     scl,
  output logic     sdaDrv,
  input wire logic sdaLine
);
  int slow = 0; // extra low time in even ns
  // clock parked high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // start or repeated start; long lead clears the ack release
  task automatic start();
    #16 sdaDrv = 1'b1;
    #8 scl = 1'b1;
    #8 sdaDrv = 1'b0;
    #8 scl = 1'b0;
  endtask
  // eight bits msb first, then the ack slot; data moves only while clock low
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #(12 + slow) sdaDrv = d[i];
      #12 scl = 1'b1;
      #6 r[i] = sdaLine;
      #2 scl = 1'b0;
    end
  endtask
  // stop closes every frame this side opened
  task automatic stop();
    #12 sdaDrv = 1'b0;
    #12 scl = 1'b1;
    #12 sdaDrv = 1'b1;
    #24;
  endtask
endmodule
`default_nettype wire

/* File: test/pmic_i2c_slave_port_tb.sv */
// self-checking bench for the control port
`timescale 1ns/1ps
`default_nettype none
module pmic_i2c_slave_port_tb;
  logic        mclk, rst_b, sel, sdaOut, sdaOe, busBusy, regWe, scl, sdaDrv;
  logic [7:0]  regAddr, regWdata, ptr = 8'h00, seed = 8'h0a;
  logic [7:0]  mem [256] = '{default: 8'h00};
  logic [15:0] expQ [$], gotQ [$];
  int          nMismatch = 0, samplesChecked = 0;
  wire logic   sdaLine = sdaDrv & (~sdaOe | sdaOut);
  wire logic [6:0] own = {6'b111001, sel};
  pmicsp_top dut (.mclk, .rst_b, .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOe,
    .targetAddressSelectPin(sel), .busBusy, .regWe, .regAddr, .regWdata);
  pmicsp_master m (.scl, .sdaDrv, .sdaLine);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // strobes as the register file would see them
  always @(posedge mclk) begin
    if (regWe === 1'b1) gotQ.push_back({regAddr, regWdata});
  end
  function automatic logic [7:0] lfsr();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one byte from the master; ok says whether an ack is due
  task automatic wr(input logic [7:0] d, input logic ok);
    logic [8:0] r;
    m.xfer({d, 1'b1}, r);
    cmp("ack", 16'(ok), 16'(!r[0]));
  endtask
  task automatic open(input logic [6:0] a, input logic dir);
    m.start();
    wr({a, dir}, a == own);
    cmp("busy", 16'h1, 16'(busBusy));
  endtask
  task automatic sub();
    open(own, 1'b0);
    wr(ptr, 1'b1);
  endtask
  // data bytes land at the pointer, which steps after each one
  task automatic data(input int n);
    logic [7:0] d;
    repeat (n) begin
      d = lfsr();
      wr(d, 1'b1);
      mem[ptr] = d;
      expQ.push_back({ptr, d});
      ptr++;
    end
  endtask
  task automatic rd(input int n);
    logic [8:0] r;
    open(own, 1'b1);
    for (int i = n; i > 0; i--) begin
      m.xfer({8'hff, i == 1}, r);
      cmp("read", 16'(mem[ptr]), 16'(r[8:1]));
      // a nacked last byte leaves the pointer where it was
      if (i > 1) ptr++;
    end
  endtask
  task automatic done();
    m.stop();
    cmp("busy", 16'h0, 16'(busBusy));
    while (expQ.size() > 0) cmp("strobe", expQ.pop_front(), gotQ.size() > 0 ? gotQ.pop_front() : 16'hxxxx);
    cmp("extra", 16'h0, 16'(gotQ.size()));
    gotQ = {};
  endtask
  initial begin
    rst_b = 1'b0;
    sel = 1'b0;
    repeat (4) @(posedge mclk);
    cmp("reset", 16'h0, {5'h0, busBusy, sdaOe, regWe, regAddr});
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    // both select levels; link edges kept off the clock edge
    for (int s = 0; s < 2; s++) begin
      @(posedge mclk) sel <= s[0];
      #1.3;
      ptr = lfsr();
      sub();
      data(3);
      done();
      ptr = ptr - 8'h03;
      sub();
      rd(2);
      done();
      rd(1);
      done();
      open(own ^ 7'h01, 1'b0);
      wr(lfsr(), 1'b0);
      done();
      m.slow = 40;
      ptr = lfsr();
      sub();
      data(1);
      done();
      m.slow = 0;
    end
    conclude();
  end
  // hang guard; the run needs about a fifth of this
  initial begin
    #60000;
    nMismatch++;
    conclude();
  end
endmodule
`default_nettype wire
